// >>> verilog/epci_irq.sv
// Purpose: flags, enables and masks for three pin irqs and two change groups
// Assumes: core gives global enable and one ack pulse per vector entry
// Notes:   vector index 0 a, 1 b, 2 c, 3 lower group, 4 upper group
// Operation
// - edge or change on pin a/b sets flag
// - pin vector needs flag, enable, global enable; low-level mode needs a low pin instead of the flag
// - vector entry clears the matching flag
// - writing one clears flag, zero keeps it
// - low-level mode holds pin a/b flag zero
// - selected edge on pin c sets flag
// - sleep buffer cut-off may set pin c flag
// - enabled upper pin change sets upper flag
// - enabled lower pin change sets lower flag
// - group vector needs flag, enable, global enable
// - mask bit plus group enable arms pin
// - cleared mask bit blocks that pin
// - legacy mode hides masks, no change irqs
// - sense codes: low, any, falling, rising
// - pin c edge select: zero falling, one rising
// - pin activity counts even as output
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "epci_defs.svh"

module epci_irq
	import epci_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [2:0]            addr,
	input  wire logic [7:0]            wdata,
	input  wire logic                  wr_en,
	input  wire logic                  rd_en,
	output logic      [7:0]            rdata,
	input  wire logic                  ext_pin_a,
	input  wire logic                  ext_pin_b,
	input  wire logic                  ext_pin_c,
	input  wire logic [7:0]            upper_change_pins,
	input  wire logic [7:0]            lower_change_pins,
	input  wire logic                  sleep_buf_off,
	input  wire logic                  gie,
	input  wire logic [`EPCI_NSRC-1:0] vec_ack,
	output logic      [`EPCI_NSRC-1:0] vec_req,
	output logic                       irq
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// register select, used by write and clear paths and by the checks
	function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
		hit = (a == off);
	endfunction : hit

	// internal source order to register bit order
	function automatic logic [7:0] pack(input logic [`EPCI_NSRC-1:0] v);
		logic [7:0] r;
		r = `EPCI_RST_8;
		r[`EPCI_RB_A] = v[`EPCI_SA];
		r[`EPCI_RB_B] = v[`EPCI_SB];
		r[`EPCI_RB_C] = v[`EPCI_SC];
		r[`EPCI_RB_L] = v[`EPCI_SL];
		r[`EPCI_RB_U] = v[`EPCI_SU];
		pack = r;
	endfunction : pack

	// register bit order to internal source order
	function automatic logic [`EPCI_NSRC-1:0] unpack(input logic [7:0] r);
		unpack = {r[`EPCI_RB_U], r[`EPCI_RB_L], r[`EPCI_RB_C],
		          r[`EPCI_RB_B], r[`EPCI_RB_A]};
	endfunction : unpack

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [`EPCI_NSRC-1:0] flags_r;
	logic [`EPCI_NSRC-1:0] flags_nxt;
	logic [`EPCI_NSRC-1:0] en_r;
	logic [7:0]            mask_u_r;
	logic [7:0]            mask_l_r;
	logic [3:0]            ctl_r;
	logic                  csel_r;
	logic                  legacy_r;
	logic [7:0]            rdata_r;
	logic [`EPCI_NPIN-1:0] smp;
	logic [`EPCI_NPIN-1:0] prev_r;
	logic                  c_cur;
	logic                  c_prev_r;
	logic [`EPCI_NSRC-1:0] set_v;
	logic [`EPCI_NSRC-1:0] clr_v;
	logic [1:0]            ab_hit;
	epci_sense_t           mode_ab [2];
	logic [7:0]            chg_u;
	logic [7:0]            chg_l;

	assign mode_ab[0] = epci_sense_t'({ctl_r[`EPCI_CTL_A_HI], ctl_r[`EPCI_CTL_A_LO]});
	assign mode_ab[1] = epci_sense_t'({ctl_r[`EPCI_CTL_B_HI], ctl_r[`EPCI_CTL_B_LO]});

	// control writes; mask writes ignored in legacy mode
	always_ff @(posedge clk) begin
		if (rst) begin
			en_r     <= `EPCI_RST_SRC;
			mask_u_r <= `EPCI_RST_8;
			mask_l_r <= `EPCI_RST_8;
			ctl_r    <= 4'h0;
			csel_r   <= 1'b0;
			legacy_r <= 1'b0;
		end else if (wr_en) begin
			if (hit(addr, `EPCI_OFF_EN))
				en_r <= unpack(wdata);
			if (hit(addr, `EPCI_OFF_MSKU) && !legacy_r)
				mask_u_r <= wdata;
			if (hit(addr, `EPCI_OFF_MSKL) && !legacy_r)
				mask_l_r <= wdata;
			if (hit(addr, `EPCI_OFF_CTL))
				ctl_r <= wdata[3:0];
			if (hit(addr, `EPCI_OFF_CTLX)) begin
				csel_r   <= wdata[`EPCI_CTLX_CSEL];
				legacy_r <= wdata[`EPCI_CTLX_LEG];
			end
		end
	end

	// ****************************************************************
	// pin sampling
	// ****************************************************************

	// pins read whatever the port direction, so outputs still trigger
	epci_sync u_sync (
		.clk    (clk),
		.rst    (rst),
		.pins   ({upper_change_pins, lower_change_pins,
		          ext_pin_c, ext_pin_b, ext_pin_a}),
		.pins_q (smp)
	);

	// previous sample for edge and change compare
	always_ff @(posedge clk) begin
		if (rst)
			prev_r <= `EPCI_RST_PIN;
		else
			prev_r <= smp;
	end

	// buffer cut in sleep with c disabled reads low; may fake an edge
	assign c_cur = smp[`EPCI_P_C] & ~(sleep_buf_off & ~en_r[`EPCI_SC]);

	always_ff @(posedge clk) begin
		if (rst)
			c_prev_r <= 1'b0;
		else
			c_prev_r <= c_cur;
	end

	// ****************************************************************
	// request detection
	// ****************************************************************

	// sense decode for pins a and b
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ab
			epci_sense u_sense (
				.cur  (smp[gi]),
				.prev (prev_r[gi]),
				.mode (mode_ab[gi]),
				.hit  (ab_hit[gi])
			);
		end
	endgenerate

	// per-pin change qualified by mask; group enable and legacy mode gate it at the set sources
	assign chg_u = (smp[`EPCI_P_U +: 8] ^ prev_r[`EPCI_P_U +: 8]) & mask_u_r;
	assign chg_l = (smp[`EPCI_P_L +: 8] ^ prev_r[`EPCI_P_L +: 8]) & mask_l_r;

	// set sources
	always_comb begin
		set_v = `EPCI_RST_SRC;
		set_v[`EPCI_SA] = ab_hit[0];
		set_v[`EPCI_SB] = ab_hit[1];
		set_v[`EPCI_SC] = csel_r ? (c_cur & ~c_prev_r)
		                         : (c_prev_r & ~c_cur);
		set_v[`EPCI_SU] = (|chg_u) & en_r[`EPCI_SU] & ~legacy_r;
		set_v[`EPCI_SL] = (|chg_l) & en_r[`EPCI_SL] & ~legacy_r;
	end

	// ****************************************************************
	// flags
	// ****************************************************************

	// clear by vector entry or by write of one
	always_comb begin
		clr_v = vec_ack;
		if (wr_en && hit(addr, `EPCI_OFF_FLAG))
			clr_v = clr_v | unpack(wdata);
	end

	// set beats clear so no event is lost in the clearing cycle
	always_comb begin
		flags_nxt = (flags_r & ~clr_v) | set_v;
		if (mode_ab[0] == epci_low)
			flags_nxt[`EPCI_SA] = 1'b0;
		if (mode_ab[1] == epci_low)
			flags_nxt[`EPCI_SB] = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst)
			flags_r <= `EPCI_RST_SRC;
		else
			flags_r <= flags_nxt;
	end

	// ****************************************************************
	// vector requests
	// ****************************************************************

	// level mode requests straight from a low pin, not from the flag
	always_comb begin
		vec_req = flags_r & en_r & {`EPCI_NSRC{gie}};
		if (mode_ab[0] == epci_low)
			vec_req[`EPCI_SA] = ~smp[0] & en_r[`EPCI_SA] & gie;
		if (mode_ab[1] == epci_low)
			vec_req[`EPCI_SB] = ~smp[1] & en_r[`EPCI_SB] & gie;
	end

	assign irq = |vec_req;

	// ****************************************************************
	// read port
	// ****************************************************************

	// data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (rst)
			rdata_r <= `EPCI_RST_8;
		else if (rd_en) begin
			case (addr)
				`EPCI_OFF_FLAG: rdata_r <= pack(flags_r);
				`EPCI_OFF_EN:   rdata_r <= pack(en_r);
				`EPCI_OFF_MSKU: rdata_r <= legacy_r ? `EPCI_RST_8 : mask_u_r;
				`EPCI_OFF_MSKL: rdata_r <= legacy_r ? `EPCI_RST_8 : mask_l_r;
				`EPCI_OFF_CTL:  rdata_r <= {4'h0, ctl_r};
				`EPCI_OFF_CTLX: rdata_r <= {6'h00, legacy_r, csel_r};
				default:        rdata_r <= `EPCI_RST_8;
			endcase
		end else
			rdata_r <= `EPCI_RST_8;
	end

	assign rdata = rdata_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence a_rise_s;
		smp[0] && !prev_r[0];
	endsequence

	flag_a_set_a: assert property (
		(mode_ab[0] == epci_rise) and a_rise_s |=> flags_r[`EPCI_SA])
		else $error("pin a rise did not set flag");

	level_zero_a: assert property (
		mode_ab[1] == epci_low |=> !flags_r[`EPCI_SB])
		else $error("pin b flag set in level mode");

	dispatch_c_a: assert property (
		vec_req[`EPCI_SC] |-> flags_r[`EPCI_SC] && en_r[`EPCI_SC] && gie)
		else $error("pin c vector without cause");

	ack_clear_a: assert property (
		vec_ack[`EPCI_SL] && !set_v[`EPCI_SL] |=> !flags_r[`EPCI_SL])
		else $error("ack did not clear lower flag");

	w1c_keep_a: assert property (
		wr_en && hit(addr, `EPCI_OFF_FLAG) && !wdata[`EPCI_RB_C]
		&& !vec_ack[`EPCI_SC] && flags_r[`EPCI_SC] |=> flags_r[`EPCI_SC])
		else $error("zero write lost pin c flag");

	c_fall_a: assert property (
		!csel_r && c_prev_r && !c_cur |=> flags_r[`EPCI_SC])
		else $error("pin c fall did not set flag");

	mask_block_a: assert property (
		mask_l_r == 8'h00 && !flags_r[`EPCI_SL] |=> !flags_r[`EPCI_SL])
		else $error("masked lower group set flag");

	legacy_block_a: assert property (
		legacy_r && !flags_r[`EPCI_SU] |=> !flags_r[`EPCI_SU])
		else $error("upper flag set in legacy mode");

	read_flag_a: assert property (
		rd_en && hit(addr, `EPCI_OFF_FLAG) |=> rdata == pack($past(flags_r)))
		else $error("flag read mismatch");

endmodule : epci_irq
`default_nettype wire

// >>> verilog/epci_defs.svh
// Purpose: offsets, field positions and reset values of the pin irq block
// Assumes: byte-wide register port, 3-bit register index
// Notes:   definitions only
`ifndef EPCI_DEFS_SVH
`define EPCI_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define EPCI_OFF_FLAG   3'h0
`define EPCI_OFF_EN     3'h1
`define EPCI_OFF_MSKU   3'h2
`define EPCI_OFF_MSKL   3'h3
`define EPCI_OFF_CTL    3'h4
`define EPCI_OFF_CTLX   3'h5

// ****************************************************************
// bit positions in the flag and enable registers
// ****************************************************************
`define EPCI_RB_B       7
`define EPCI_RB_A       6
`define EPCI_RB_C       5
`define EPCI_RB_U       4
`define EPCI_RB_L       3

// internal source index: a, b, c, lower group, upper group
`define EPCI_SA         0
`define EPCI_SB         1
`define EPCI_SC         2
`define EPCI_SL         3
`define EPCI_SU         4
`define EPCI_NSRC       5

// control register fields
`define EPCI_CTL_A_LO   0
`define EPCI_CTL_A_HI   1
`define EPCI_CTL_B_LO   2
`define EPCI_CTL_B_HI   3
`define EPCI_CTLX_CSEL  0
`define EPCI_CTLX_LEG   1

// synchronised pin vector layout: a, b, c, lower[7:0], upper[7:0]
`define EPCI_NPIN       19
`define EPCI_P_C        2
`define EPCI_P_L        3
`define EPCI_P_U        11

// reset values
`define EPCI_RST_8      8'h00
`define EPCI_RST_SRC    5'h00
`define EPCI_RST_PIN    19'h00000

`endif

// >>> verilog/epci_pkg.sv
// Purpose: types shared by the pin irq block
// Assumes: nothing
// Notes:   sense codes follow the two-bit control field
package epci_pkg;

	// two-bit sense selection for pins a and b
	typedef enum logic [1:0] {
		epci_low  = 2'b00,
		epci_any  = 2'b01,
		epci_fall = 2'b10,
		epci_rise = 2'b11
	} epci_sense_t;

endpackage : epci_pkg

// >>> verilog/epci_sync.sv
// Purpose: two-stage synchroniser for every asynchronous pin
// Assumes: pins are unrelated to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
`include "epci_defs.svh"

module epci_sync
	import epci_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [`EPCI_NPIN-1:0]  pins,
	output logic      [`EPCI_NPIN-1:0]  pins_q
);

	logic [`EPCI_NPIN-1:0] meta_r;

	// two flops per pin against metastability
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= `EPCI_RST_PIN;
			pins_q <= `EPCI_RST_PIN;
		end else begin
			meta_r <= pins;
			pins_q <= meta_r;
		end
	end

endmodule : epci_sync
`default_nettype wire

// >>> verilog/epci_sense.sv
// Purpose: turns a sampled pin pair into a request per sense mode
// Assumes: cur and prev are consecutive samples on clk
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none

module epci_sense
	import epci_pkg::*;
(
	input  wire logic        cur,
	input  wire logic        prev,
	input  wire epci_sense_t mode,
	output logic             hit
);

	// low level gives no edge request; the flag stays clear there
	always_comb begin
		case (mode)
			epci_any:  hit = cur ^ prev;
			epci_fall: hit = prev & ~cur;
			epci_rise: hit = cur & ~prev;
			default:   hit = 1'b0;
		endcase
	end

endmodule : epci_sense
`default_nettype wire

// >>> testbench/epci_pin_model.sv
// Purpose: board-side model of the pins that feed the pin irq block
// Assumes: the bench names the wanted levels; they reach the pins one edge later
// Notes:   levels change only just after a rising edge and last whole cycles
`timescale 1ns/1ps
`default_nettype none

module epci_pin_model (
	input  wire logic       clk,
	input  wire logic [2:0] want_abc,
	input  wire logic [7:0] want_up,
	input  wire logic [7:0] want_lo,
	output logic      [2:0] pin_abc,
	output logic      [7:0] pin_up,
	output logic      [7:0] pin_lo
);
	// ****************************************************************
	// pin drive
	// ****************************************************************
	// one driver per pin: wanted levels start low, so the pins settle low
	// on the first edge, well inside reset, and no false edge follows it
	// whole-cycle levels: no pulse shorter than a clock, which the block may miss
	// driven as plain levels whatever the port direction would be
	always @(posedge clk) begin
		pin_abc <= want_abc;
		pin_up  <= want_up;
		pin_lo  <= want_lo;
	end
endmodule : epci_pin_model
`default_nettype wire

// >>> testbench/ext_pin_change_irq_tb.sv
// Purpose: self-checking bench for the pin irq block
// Assumes: byte-wide register port with one-cycle strobes, pins through epci_pin_model
// Notes:   read results are queued notes, checked by a watcher one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "epci_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end

module ext_pin_change_irq_tb
	import epci_pkg::*;
;
	logic       clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_q = 1'b0;
	logic       sleep_buf_off = 1'b0, gie = 1'b0, irq;
	logic [2:0] addr = 3'h0, want_abc = 3'h0, pin_abc;
	logic [7:0] wdata = 8'h00, want_up = 8'h00, want_lo = 8'h00, pin_up, pin_lo, rdata, ev;
	logic [4:0] vec_ack = 5'h00, vec_req;
	logic [7:0] exp_q [$];
	int         n_errors = 0, check_count = 0, cyc = 0, seed = 32'ha596;

	// ****************************************************************
	// clock, instances, watchers
	// ****************************************************************
	always #4 clk = ~clk;

	epci_irq dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .ext_pin_a(pin_abc[0]), .ext_pin_b(pin_abc[1]),
		.ext_pin_c(pin_abc[2]), .upper_change_pins(pin_up), .lower_change_pins(pin_lo),
		.sleep_buf_off(sleep_buf_off), .gie(gie), .vec_ack(vec_ack), .vec_req(vec_req),
		.irq(irq));

	epci_pin_model pins_m (.clk(clk), .want_abc(want_abc), .want_up(want_up),
		.want_lo(want_lo), .pin_abc(pin_abc), .pin_up(pin_up), .pin_lo(pin_lo));

	// read data stands only in the cycle after the strobe, so look mid-cycle
	always @(posedge clk) rd_q <= rd_en;
	always @(negedge clk) begin
		if (rd_q) begin
			ev = exp_q.pop_front();
			`CHK("rdata", ev, rdata)
		end
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// strobe tasks end one edge after the strobe drops, so calls never collide
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
	endtask : rd

	// six edges cover model, two sync stages and the flag update
	task automatic pins(input logic [2:0] abc, input logic [7:0] up, input logic [7:0] lo);
		want_abc <= abc;
		want_up <= up;
		want_lo <= lo;
		tick(6);
	endtask : pins

	task automatic req(input logic [4:0] e);
		@(negedge clk);
		`CHK("vec_req", e, vec_req)
		`CHK("irq", |e, irq)
		@(posedge clk);
	endtask : req

	task automatic ack(input logic [4:0] v);
		vec_ack <= v;
		@(posedge clk);
		vec_ack <= 5'h00;
	endtask : ack

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		int         m;
		logic [7:0] r;
		tick(2);
		rst <= 1'b0;
		// reset values, unmapped slots read zero
		for (m = 0; m < 8; m++) rd(m[2:0], 8'h00);
		req(5'h00);
		// every edge sense code on pins a and b together
		for (m = 1; m < 4; m++) begin
			wr(`EPCI_OFF_CTL, {4'h0, m[1:0], m[1:0]});
			wr(`EPCI_OFF_FLAG, 8'hff);
			pins(3'b011, 8'h00, 8'h00);
			rd(`EPCI_OFF_FLAG, (m != 2) ? 8'hc0 : 8'h00);
			wr(`EPCI_OFF_FLAG, 8'hff);
			pins(3'b000, 8'h00, 8'h00);
			rd(`EPCI_OFF_FLAG, (m != 3) ? 8'hc0 : 8'h00);
		end
		// low level mode: request follows the pin, flag stays clear
		gie <= 1'b1;
		wr(`EPCI_OFF_CTL, {6'h00, epci_low});
		wr(`EPCI_OFF_EN, 8'h40);
		tick(4);
		req(5'h01);
		rd(`EPCI_OFF_FLAG, 8'h00);
		pins(3'b001, 8'h00, 8'h00);
		req(5'h00);
		// rising edge on a, gated by global enable, cleared by ack and by one
		wr(`EPCI_OFF_CTL, {6'h00, epci_rise});
		gie <= 1'b0;
		pins(3'b000, 8'h00, 8'h00);
		pins(3'b001, 8'h00, 8'h00);
		req(5'h00);
		gie <= 1'b1;
		req(5'h01);
		wr(`EPCI_OFF_FLAG, 8'hbf);
		rd(`EPCI_OFF_FLAG, 8'h40);
		ack(5'h01);
		req(5'h00);
		pins(3'b000, 8'h00, 8'h00);
		pins(3'b001, 8'h00, 8'h00);
		wr(`EPCI_OFF_FLAG, 8'h40);
		rd(`EPCI_OFF_FLAG, 8'h00);
		// pin c: falling select ignores a rise, then both selects
		wr(`EPCI_OFF_EN, 8'h20);
		pins(3'b101, 8'h00, 8'h00);
		rd(`EPCI_OFF_FLAG, 8'h00);
		pins(3'b001, 8'h00, 8'h00);
		rd(`EPCI_OFF_FLAG, 8'h20);
		req(5'h04);
		wr(`EPCI_OFF_CTLX, 8'h01);
		wr(`EPCI_OFF_FLAG, 8'h20);
		pins(3'b101, 8'h00, 8'h00);
		rd(`EPCI_OFF_FLAG, 8'h20);
		// sleep cut-off with pin c disabled reads the pin low: a fall
		wr(`EPCI_OFF_EN, 8'h00);
		wr(`EPCI_OFF_CTLX, 8'h00);
		wr(`EPCI_OFF_FLAG, 8'hff);
		sleep_buf_off <= 1'b1;
		tick(5);
		rd(`EPCI_OFF_FLAG, 8'h20);
		sleep_buf_off <= 1'b0;
		pins(3'b000, 8'h00, 8'h00);
		wr(`EPCI_OFF_FLAG, 8'hff);
		// random masks, one pin of each group toggled per pass
		wr(`EPCI_OFF_EN, 8'h18);
		for (m = 0; m < 8; m++) begin
			r = 8'($random(seed));
			wr(`EPCI_OFF_MSKU, r);
			wr(`EPCI_OFF_MSKL, ~r);
			rd(`EPCI_OFF_MSKU, r);
			pins(3'b000, want_up ^ (8'h01 << m), want_lo ^ (8'h01 << m));
			rd(`EPCI_OFF_FLAG, {3'b000, r[m], ~r[m], 3'b000});
			req({r[m], ~r[m], 3'b000});
			ack(5'h18);
			req(5'h00);
		end
		// all lower mask bits clear with the group enabled: every change is ignored
		wr(`EPCI_OFF_MSKL, 8'h00);
		pins(3'b000, want_up, ~want_lo);
		rd(`EPCI_OFF_FLAG, 8'h00);
		// legacy mode hides the masks and stops group requests
		wr(`EPCI_OFF_CTLX, 8'h02);
		rd(`EPCI_OFF_MSKU, 8'h00);
		pins(3'b000, ~want_up, ~want_lo);
		rd(`EPCI_OFF_FLAG, 8'h00);
		tick(2);
		stop_test();
	end
endmodule : ext_pin_change_irq_tb
`default_nettype wire
